//--- shared/pbs_map.svh
// Address map, field positions, reset values and timing for the PLL bring-up controller
`ifndef PBS_MAP_SVH
`define PBS_MAP_SVH

// Host register offsets (byte addresses, one 32-bit word each)
`define PBS_OFS_CMD      8'h00
`define PBS_OFS_DIV      8'h04
`define PBS_OFS_FILT     8'h08
`define PBS_OFS_MUL      8'h0C
`define PBS_OFS_FLASH    8'h10
`define PBS_OFS_FALLBACK 8'h14
`define PBS_OFS_STATUS   8'h18

// Command register bits
`define PBS_CMD_BRINGUP  0
`define PBS_CMD_RECONF   1
`define PBS_CMD_EXTREF   2
`define PBS_CMD_FASTER   3

// Status register bits
`define PBS_STS_BUSY     0
`define PBS_STS_DONE     1
`define PBS_STS_LOCK     2
`define PBS_STS_CACHE    3
`define PBS_STS_RECONF   4
`define PBS_STS_STEP_LSB 8

// Device register addresses on the device's register port
`define PBS_SFR_CTL      8'h01
`define PBS_SFR_DIV      8'h02
`define PBS_SFR_FILT     8'h03
`define PBS_SFR_MUL      8'h04
`define PBS_SFR_FLASH    8'h05
`define PBS_SFR_SYSCLK   8'h06

// Device field positions
`define PBS_CTL_PWR      0
`define PBS_CTL_RUN      1
`define PBS_CTL_SRC      2
`define PBS_CTL_LOCK     4
`define PBS_FLT_LOOP_LSB 0
`define PBS_FLT_OSC_LSB  4
`define PBS_FLASH_RT_LSB 4

// System clock source codes
`define PBS_SYSCLK_INT   3'h0
`define PBS_SYSCLK_EXT   3'h1
`define PBS_SYSCLK_PLL   3'h4

// Reset values
`define PBS_RST_BYTE     8'h00
`define PBS_RST_WORD     32'h0000_0000

// Timing
`define PBS_LOCK_WAIT_NS 5000
`define PBS_CLK_PERIOD_NS 5

`endif

//--- shared/pbs_pkg.sv
// Types shared by the PLL bring-up controller modules
package pbs_pkg;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_FETCH = 6'h02,
        ST_REF   = 6'h04,
        ST_BUS   = 6'h08,
        ST_DELAY = 6'h10,
        ST_POLL  = 6'h20
    } pbs_state_e;

    typedef enum logic [2:0] {
        OP_WRITE    = 3'h0,
        OP_QUIET_WR = 3'h1,
        OP_WAIT_REF = 3'h2,
        OP_WAIT_FB  = 3'h3,
        OP_DELAY    = 3'h4,
        OP_POLL     = 3'h5,
        OP_SKIP     = 3'h6,
        OP_END      = 3'h7
    } pbs_op_e;

    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [7:0] data;
    } pbs_sfr_req_s;

    typedef struct packed {
        pbs_op_e      kind;
        pbs_sfr_req_s req;
    } pbs_op_s;

    typedef struct packed {
        logic       extRef;
        logic       faster;
        logic [7:0] div;
        logic [3:0] loopRange;
        logic [1:0] oscRange;
        logic [7:0] mul;
        logic [1:0] flashTiming;
        logic [2:0] fallback;
    } pbs_cfg_s;

    typedef struct packed {
        pbs_state_e  state;
        logic [3:0]  step;
        logic        reconf;
        logic        waitExt;
        logic        busy;
        logic        done;
        logic        lockSeen;
        logic        cacheOff;
        pbs_cfg_s    cfg;
        logic [1:0]  refSync1;
        logic [1:0]  refSync2;
        logic [31:0] rdata;
    } pbs_seq_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       write;
        logic       read;
        logic       capture;
        logic       done;
        logic [7:0] rdata;
    } pbs_sfr_s;

    typedef struct packed {
        logic [11:0] count;
        logic        armed;
    } pbs_timer_s;

endpackage : pbs_pkg

//--- rtl/pbs_wait_timer.sv
// Down-counter that reports when a loaded number of cycles has passed
`timescale 1ns/1ps
`include "pbs_map.svh"

module pbs_wait_timer (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic [11:0] cycles,
    output logic             expired
);
    pbs_pkg::pbs_timer_s cur;
    pbs_pkg::pbs_timer_s next_cur;

    always_comb begin
        next_cur = cur;
        if (start) begin
            next_cur.count = cycles;
            next_cur.armed = 1'b1;
        end else if (cur.count != 12'h000) begin
            next_cur.count = cur.count - 12'h001;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign expired = cur.armed && (cur.count == 12'h000);
endmodule : pbs_wait_timer

//--- rtl/pbs_sfr_master.sv
// Drives the device register port: one-cycle writes, reads with data one cycle later
`timescale 1ns/1ps
`include "pbs_map.svh"

module pbs_sfr_master (
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic                  reqValid,
    input  wire pbs_pkg::pbs_sfr_req_s req,
    output logic                       done,
    output logic [7:0]                 rdata,
    output logic [7:0]                 devAddr,
    output logic [7:0]                 devWdata,
    output logic                       devWrite,
    output logic                       devRead,
    input  wire logic [7:0]            devRdata
);
    pbs_pkg::pbs_sfr_s cur;
    pbs_pkg::pbs_sfr_s next_cur;

    always_comb begin
        next_cur         = cur;
        next_cur.write   = 1'b0;
        next_cur.read    = 1'b0;
        next_cur.done    = 1'b0;
        next_cur.capture = cur.read;
        if (reqValid) begin
            next_cur.addr  = req.addr;
            next_cur.wdata = req.write ? req.data : `PBS_RST_BYTE;
            next_cur.write = req.write;
            next_cur.read  = !req.write;
            next_cur.done  = req.write;
        end
        // Read data stands on the port in the cycle after the read strobe
        if (cur.capture) begin
            next_cur.rdata = devRdata;
            next_cur.done  = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign done     = cur.done;
    assign rdata    = cur.rdata;
    assign devAddr  = cur.addr;
    assign devWdata = cur.wdata;
    assign devWrite = cur.write;
    assign devRead  = cur.read;
endmodule : pbs_sfr_master

//--- rtl/pbs_sequencer.sv
// Host controller that brings up and reconfigures the device PLL over its register port
`timescale 1ns/1ps
`include "pbs_map.svh"

// Functional notes
// - lock bit rises; software polls until set
// - loop filter range written before enabling
// - oscillator range written before enabling
// - wait 5 us before first enable
// - reference must be stable before selection
// - select PLL system clock only after lock
// - move system clock off PLL first
// - clear run bit before rewriting settings
// - raise flash timing before faster clock
// - lower flash timing after clock switch
// - caches off while lowering flash timing
module pbs_sequencer (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [7:0]  hostAddr,
    input  wire logic [31:0] hostWdata,
    input  wire logic        hostWrite,
    input  wire logic        hostRead,
    output logic [31:0]      hostRdata,
    input  wire logic        refStableInt,
    input  wire logic        refStableExt,
    output logic [7:0]       devAddr,
    output logic [7:0]       devWdata,
    output logic             devWrite,
    output logic             devRead,
    input  wire logic [7:0]  devRdata,
    output logic             cacheOff
);
    localparam int LockWaitCycles =
        (`PBS_LOCK_WAIT_NS + `PBS_CLK_PERIOD_NS - 1) / `PBS_CLK_PERIOD_NS;
    localparam logic [11:0] LockWaitCount =
        12'(LockWaitCycles < 1 ? 1 : LockWaitCycles);

    logic [1:0]            rstPipe;
    logic                  rstSyncN;
    pbs_pkg::pbs_seq_s     cur;
    pbs_pkg::pbs_seq_s     next_cur;
    pbs_pkg::pbs_op_s      op;
    logic                  reqValid;
    pbs_pkg::pbs_sfr_req_s req;
    logic                  reqDone;
    logic [7:0]            reqRdata;
    logic                  timerStart;
    logic                  timerExpired;
    logic                  refOk;
    logic                  startBringup;
    logic                  startReconf;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe[1];

    function automatic pbs_pkg::pbs_op_s wr(input logic [7:0] addr, input logic [7:0] data);
        wr.kind      = pbs_pkg::OP_WRITE;
        wr.req.write = 1'b1;
        wr.req.addr  = addr;
        wr.req.data  = data;
    endfunction : wr

    function automatic pbs_pkg::pbs_op_s kindOnly(input pbs_pkg::pbs_op_e kind);
        kindOnly.kind      = kind;
        kindOnly.req.write = 1'b0;
        kindOnly.req.addr  = `PBS_SFR_CTL;
        kindOnly.req.data  = `PBS_RST_BYTE;
    endfunction : kindOnly

    function automatic logic [7:0] ctlByte(input logic src, input logic pwr, input logic run);
        ctlByte               = `PBS_RST_BYTE;
        ctlByte[`PBS_CTL_SRC] = src;
        ctlByte[`PBS_CTL_PWR] = pwr;
        ctlByte[`PBS_CTL_RUN] = run;
    endfunction : ctlByte

    function automatic logic [7:0] filtByte(input pbs_pkg::pbs_cfg_s cfg);
        filtByte                          = `PBS_RST_BYTE;
        filtByte[`PBS_FLT_LOOP_LSB +: 4] = cfg.loopRange;
        filtByte[`PBS_FLT_OSC_LSB +: 2]  = cfg.oscRange;
    endfunction : filtByte

    function automatic logic [7:0] flashByte(input pbs_pkg::pbs_cfg_s cfg);
        flashByte                          = `PBS_RST_BYTE;
        flashByte[`PBS_FLASH_RT_LSB +: 2] = cfg.flashTiming;
    endfunction : flashByte

    function automatic logic [7:0] clkByte(input logic [2:0] sel);
        clkByte = {5'h00, sel};
    endfunction : clkByte

    // Microprogram: one operation per step for each procedure
    function automatic pbs_pkg::pbs_op_s opFor(
        input logic              reconf,
        input logic [3:0]        step,
        input pbs_pkg::pbs_cfg_s cfg
    );
        pbs_pkg::pbs_op_s o;
        o = kindOnly(pbs_pkg::OP_END);
        if (!reconf) begin
            case (step)
                4'h0: o = kindOnly(pbs_pkg::OP_WAIT_REF);
                4'h1: o = wr(`PBS_SFR_CTL, ctlByte(cfg.extRef, 1'b0, 1'b0));
                4'h2: o = wr(`PBS_SFR_FLASH, flashByte(cfg));
                4'h3: o = wr(`PBS_SFR_CTL, ctlByte(cfg.extRef, 1'b1, 1'b0));
                4'h4: o = wr(`PBS_SFR_DIV, cfg.div);
                4'h5: o = wr(`PBS_SFR_FILT, filtByte(cfg));
                4'h6: o = wr(`PBS_SFR_MUL, cfg.mul);
                4'h7: o = kindOnly(pbs_pkg::OP_DELAY);
                4'h8: o = wr(`PBS_SFR_CTL, ctlByte(cfg.extRef, 1'b1, 1'b1));
                4'h9: o = kindOnly(pbs_pkg::OP_POLL);
                4'hA: o = wr(`PBS_SFR_SYSCLK, clkByte(`PBS_SYSCLK_PLL));
                default: o = kindOnly(pbs_pkg::OP_END);
            endcase
        end else begin
            case (step)
                4'h0: o = kindOnly(pbs_pkg::OP_WAIT_FB);
                4'h1: o = wr(`PBS_SFR_SYSCLK, clkByte(cfg.fallback));
                4'h2: o = kindOnly(pbs_pkg::OP_WAIT_REF);
                4'h3: o = wr(`PBS_SFR_CTL, ctlByte(cfg.extRef, 1'b1, 1'b1));
                4'h4: begin
                    if (cfg.faster) begin
                        o = wr(`PBS_SFR_FLASH, flashByte(cfg));
                    end else begin
                        o = kindOnly(pbs_pkg::OP_SKIP);
                    end
                end
                4'h5: o = wr(`PBS_SFR_CTL, ctlByte(cfg.extRef, 1'b1, 1'b0));
                4'h6: o = wr(`PBS_SFR_DIV, cfg.div);
                4'h7: o = wr(`PBS_SFR_FILT, filtByte(cfg));
                4'h8: o = wr(`PBS_SFR_MUL, cfg.mul);
                4'h9: o = wr(`PBS_SFR_CTL, ctlByte(cfg.extRef, 1'b1, 1'b1));
                4'hA: o = kindOnly(pbs_pkg::OP_POLL);
                4'hB: o = wr(`PBS_SFR_SYSCLK, clkByte(`PBS_SYSCLK_PLL));
                4'hC: begin
                    if (!cfg.faster) begin
                        o = wr(`PBS_SFR_FLASH, flashByte(cfg));
                        o.kind = pbs_pkg::OP_QUIET_WR;
                    end else begin
                        o = kindOnly(pbs_pkg::OP_SKIP);
                    end
                end
                default: o = kindOnly(pbs_pkg::OP_END);
            endcase
        end
        return o;
    endfunction : opFor

    assign op           = opFor(cur.reconf, cur.step, cur.cfg);
    assign refOk        = cur.waitExt ? cur.refSync2[1] : cur.refSync2[0];
    assign startBringup = hostWrite && (hostAddr == `PBS_OFS_CMD) && !cur.busy
                          && hostWdata[`PBS_CMD_BRINGUP];
    assign startReconf  = hostWrite && (hostAddr == `PBS_OFS_CMD) && !cur.busy
                          && !hostWdata[`PBS_CMD_BRINGUP] && hostWdata[`PBS_CMD_RECONF];

    always_comb begin
        next_cur       = cur;
        next_cur.rdata = `PBS_RST_WORD;
        reqValid       = 1'b0;
        req            = op.req;
        timerStart     = 1'b0;

        // Stability flags come from outside the clock domain
        next_cur.refSync1 = {refStableExt, refStableInt};
        next_cur.refSync2 = cur.refSync1;

        // Register writes; configuration is frozen while a procedure runs
        if (hostWrite && !cur.busy) begin
            unique case (hostAddr)
                `PBS_OFS_CMD: begin
                    next_cur.cfg.extRef = hostWdata[`PBS_CMD_EXTREF];
                    next_cur.cfg.faster = hostWdata[`PBS_CMD_FASTER];
                end
                `PBS_OFS_DIV:   next_cur.cfg.div = hostWdata[7:0];
                `PBS_OFS_FILT: begin
                    next_cur.cfg.loopRange = hostWdata[`PBS_FLT_LOOP_LSB +: 4];
                    next_cur.cfg.oscRange  = hostWdata[`PBS_FLT_OSC_LSB +: 2];
                end
                `PBS_OFS_MUL:      next_cur.cfg.mul = hostWdata[7:0];
                `PBS_OFS_FLASH:    next_cur.cfg.flashTiming = hostWdata[1:0];
                `PBS_OFS_FALLBACK: next_cur.cfg.fallback = hostWdata[2:0];
                default: ;
            endcase
        end

        if (startBringup || startReconf) begin
            next_cur.busy     = 1'b1;
            next_cur.done     = 1'b0;
            next_cur.lockSeen = 1'b0;
            next_cur.reconf   = startReconf;
            next_cur.step     = 4'h0;
            next_cur.state    = pbs_pkg::ST_FETCH;
        end

        if (hostRead) begin
            unique case (hostAddr)
                `PBS_OFS_CMD: begin
                    next_cur.rdata[`PBS_CMD_EXTREF] = cur.cfg.extRef;
                    next_cur.rdata[`PBS_CMD_FASTER] = cur.cfg.faster;
                end
                `PBS_OFS_DIV:  next_cur.rdata[7:0] = cur.cfg.div;
                `PBS_OFS_FILT: next_cur.rdata[7:0] = filtByte(cur.cfg);
                `PBS_OFS_MUL:  next_cur.rdata[7:0] = cur.cfg.mul;
                `PBS_OFS_FLASH:    next_cur.rdata[1:0] = cur.cfg.flashTiming;
                `PBS_OFS_FALLBACK: next_cur.rdata[2:0] = cur.cfg.fallback;
                `PBS_OFS_STATUS: begin
                    next_cur.rdata[`PBS_STS_BUSY]   = cur.busy;
                    next_cur.rdata[`PBS_STS_DONE]   = cur.done;
                    next_cur.rdata[`PBS_STS_LOCK]   = cur.lockSeen;
                    next_cur.rdata[`PBS_STS_CACHE]  = cur.cacheOff;
                    next_cur.rdata[`PBS_STS_RECONF] = cur.reconf;
                    next_cur.rdata[`PBS_STS_STEP_LSB +: 4] = cur.step;
                end
                default: ;
            endcase
        end

        unique case (cur.state)
            pbs_pkg::ST_IDLE: ;
            pbs_pkg::ST_FETCH: begin
                unique case (op.kind)
                    pbs_pkg::OP_WRITE, pbs_pkg::OP_QUIET_WR: begin
                        // Caches go off one cycle ahead of the lowering write
                        if (op.kind == pbs_pkg::OP_QUIET_WR && !cur.cacheOff) begin
                            next_cur.cacheOff = 1'b1;
                        end else begin
                            reqValid       = 1'b1;
                            next_cur.state = pbs_pkg::ST_BUS;
                        end
                    end
                    pbs_pkg::OP_WAIT_REF: begin
                        next_cur.waitExt = cur.cfg.extRef;
                        next_cur.state   = pbs_pkg::ST_REF;
                    end
                    pbs_pkg::OP_WAIT_FB: begin
                        next_cur.waitExt = (cur.cfg.fallback == `PBS_SYSCLK_EXT);
                        next_cur.state   = pbs_pkg::ST_REF;
                    end
                    pbs_pkg::OP_DELAY: begin
                        timerStart     = 1'b1;
                        next_cur.state = pbs_pkg::ST_DELAY;
                    end
                    pbs_pkg::OP_POLL: begin
                        reqValid       = 1'b1;
                        req.write      = 1'b0;
                        req.addr       = `PBS_SFR_CTL;
                        next_cur.state = pbs_pkg::ST_POLL;
                    end
                    pbs_pkg::OP_SKIP: begin
                        next_cur.step = cur.step + 4'h1;
                    end
                    pbs_pkg::OP_END: begin
                        next_cur.busy     = 1'b0;
                        next_cur.done     = 1'b1;
                        next_cur.cacheOff = 1'b0;
                        next_cur.state    = pbs_pkg::ST_IDLE;
                    end
                endcase
            end
            pbs_pkg::ST_REF: begin
                if (refOk) begin
                    next_cur.step  = cur.step + 4'h1;
                    next_cur.state = pbs_pkg::ST_FETCH;
                end
            end
            pbs_pkg::ST_BUS: begin
                if (reqDone) begin
                    next_cur.cacheOff = 1'b0;
                    next_cur.step     = cur.step + 4'h1;
                    next_cur.state    = pbs_pkg::ST_FETCH;
                end
            end
            pbs_pkg::ST_DELAY: begin
                if (timerExpired) begin
                    next_cur.step  = cur.step + 4'h1;
                    next_cur.state = pbs_pkg::ST_FETCH;
                end
            end
            pbs_pkg::ST_POLL: begin
                if (reqDone) begin
                    // Not yet locked: fetch the same poll step again
                    if (reqRdata[`PBS_CTL_LOCK]) begin
                        next_cur.lockSeen = 1'b1;
                        next_cur.step     = cur.step + 4'h1;
                    end
                    next_cur.state = pbs_pkg::ST_FETCH;
                end
            end
            default: next_cur.state = pbs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            cur                 <= '0;
            cur.state           <= pbs_pkg::ST_IDLE;
            cur.cfg.fallback    <= `PBS_SYSCLK_INT;
        end else begin
            cur <= next_cur;
        end
    end

    pbs_sfr_master u_sfr (
        .clock    (clock),
        .rstn     (rstSyncN),
        .reqValid (reqValid),
        .req      (req),
        .done     (reqDone),
        .rdata    (reqRdata),
        .devAddr  (devAddr),
        .devWdata (devWdata),
        .devWrite (devWrite),
        .devRead  (devRead),
        .devRdata (devRdata)
    );

    pbs_wait_timer u_timer (
        .clock   (clock),
        .rstn    (rstSyncN),
        .start   (timerStart),
        .cycles  (LockWaitCount),
        .expired (timerExpired)
    );

    assign hostRdata = cur.rdata;
    assign cacheOff  = cur.cacheOff;
endmodule : pbs_sequencer

//--- testbench/pbs_sequencer_asserts.sv
// Concurrent checks on the PLL bring-up controller ports
`timescale 1ns/1ps
`include "pbs_map.svh"
module pbs_sequencer_asserts (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        hostRead,
    input wire logic [31:0] hostRdata,
    input wire logic [7:0]  devAddr,
    input wire logic [7:0]  devWdata,
    input wire logic        devWrite,
    input wire logic        devRead,
    input wire logic [7:0]  devRdata,
    input wire logic        cacheOff
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic       run, sysPll, lockOk, rdCtl;
    logic [1:0] flash;
    wire        lower = devWrite && devAddr == `PBS_SFR_FLASH && devWdata[5:4] < flash;
    // Shadow of what the controller has told and learned from the device
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {run, sysPll, lockOk, rdCtl, flash} <= '0;
        end else begin
            rdCtl <= devRead && devAddr == `PBS_SFR_CTL;
            if (rdCtl && devRdata[`PBS_CTL_LOCK]) lockOk <= 1'b1;
            if (devWrite && devAddr == `PBS_SFR_CTL) begin
                run <= devWdata[`PBS_CTL_RUN];
                if (!devWdata[`PBS_CTL_RUN]) lockOk <= 1'b0;
            end
            if (devWrite && devAddr == `PBS_SFR_SYSCLK) sysPll <= devWdata[2:0] == 3'h4;
            if (devWrite && devAddr == `PBS_SFR_FLASH) flash <= devWdata[5:4];
        end
    end
    a_one_strobe: assert property (!(devWrite && devRead)) else $error("two strobes");
    a_write_gap: assert property (devWrite |=> !devWrite && !devRead) else $error("write gap");
    a_read_gap: assert property (devRead |=> (!devWrite && !devRead)[*3]) else $error("read gap");
    a_rdata_idle: assert property (!hostRead |=> hostRdata == 32'h0) else $error("rdata");
    a_pll_lock: assert property (
        devWrite && devAddr == `PBS_SFR_SYSCLK && devWdata[2:0] == 3'h4 |-> lockOk)
        else $error("pll select before lock");
    a_stop_tune: assert property (
        devWrite && devAddr inside {`PBS_SFR_DIV, `PBS_SFR_FILT, `PBS_SFR_MUL} |-> !run)
        else $error("tuning while running");
    a_off_pll: assert property (
        devWrite && devAddr inside {[`PBS_SFR_CTL:`PBS_SFR_MUL]} |-> !sysPll) else $error("on pll");
    a_cache_lower: assert property (lower |-> cacheOff && $past(cacheOff))
        else $error("cache on");
    a_lower_after: assert property (lower |-> sysPll) else $error("early lower");
    c_lock: cover property (rdCtl && devRdata[`PBS_CTL_LOCK]);
    c_pll: cover property (devWrite && devAddr == `PBS_SFR_SYSCLK && devWdata[2:0] == 3'h4);
    c_cache: cover property ($rose(cacheOff));
endmodule : pbs_sequencer_asserts

//--- testbench/pbs_dev_model.sv
// Behavioural device with PLL control, tuning, flash timing and clock select
`timescale 1ns/1ps
`include "pbs_map.svh"
module pbs_dev_model #(
    parameter int LOCK_CYC = 20
) (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [7:0] devAddr,
    input  wire logic [7:0] devWdata,
    input  wire logic       devWrite,
    input  wire logic       devRead,
    output logic      [7:0] devRdata
);
    logic [7:0] ctl, div, filt, mul, flash, sysclk, rdv;
    int         lockCnt, gap, runGap, ctlWrites;
    // Lock needs power, run and a nonzero divider and multiplier
    wire locked = ctl[0] && ctl[1] && div != 0 && mul != 0 && lockCnt >= LOCK_CYC;
    always_comb begin
        case (devAddr)
            `PBS_SFR_CTL:    rdv = {3'h0, locked, 1'b0, ctl[2:0]};
            `PBS_SFR_DIV:    rdv = div;
            `PBS_SFR_FILT:   rdv = filt;
            `PBS_SFR_MUL:    rdv = mul;
            `PBS_SFR_FLASH:  rdv = flash;
            `PBS_SFR_SYSCLK: rdv = sysclk;
            default:         rdv = 8'h00;
        endcase
    end
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {ctl, div, filt, mul, flash, sysclk, devRdata} <= '0;
            {lockCnt, gap, runGap, ctlWrites} <= '0;
        end else begin
            lockCnt <= (ctl[0] && ctl[1]) ? lockCnt + 1 : 0;
            gap <= (devWrite && devAddr == `PBS_SFR_MUL) ? 0 : gap + 1;
            // Outside a read answer the data lines show a changing pattern
            devRdata <= devRead ? rdv : ~devRdata;
            if (devWrite && devAddr == `PBS_SFR_CTL) begin
                ctl <= devWdata & 8'h07;
                ctlWrites <= ctlWrites + 1;
                if (devWdata[1] && !ctl[1]) runGap <= gap;
            end
            if (devWrite && devAddr == `PBS_SFR_DIV) div <= devWdata;
            if (devWrite && devAddr == `PBS_SFR_FILT) filt <= devWdata & 8'h3F;
            if (devWrite && devAddr == `PBS_SFR_MUL) mul <= devWdata;
            if (devWrite && devAddr == `PBS_SFR_FLASH) flash <= devWdata & 8'h30;
            if (devWrite && devAddr == `PBS_SFR_SYSCLK) sysclk <= devWdata & 8'h07;
        end
    end
endmodule : pbs_dev_model

//--- testbench/test_pbs_sequencer.sv
// Self-checking bench for the PLL bring-up controller
`timescale 1ns/1ps
`include "pbs_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t got %h want %h", $time, g, e); end end
module test_pbs_sequencer;
    typedef struct packed { logic [7:0] a; logic [31:0] w; logic [31:0] r; } pbs_row_s;
    logic        clock, rstn, hostWrite, hostRead, refStableInt, refStableExt;
    logic        devWrite, devRead, cacheOff;
    logic [7:0]  hostAddr, devAddr, devWdata, devRdata;
    logic [31:0] hostWdata, hostRdata, v;
    int          num_errors, checks_done;
    pbs_row_s    rows [7] = '{'{`PBS_OFS_DIV, 32'hFFFF_FFFF, 32'hFF},
        '{`PBS_OFS_FILT, 32'hFFFF_FFFF, 32'h3F}, '{`PBS_OFS_MUL, 32'hFFFF_FFFF, 32'hFF},
        '{`PBS_OFS_FLASH, 32'hFFFF_FFFF, 32'h3}, '{`PBS_OFS_FALLBACK, 32'hFFFF_FFFF, 32'h7},
        '{`PBS_OFS_CMD, 32'hFFFF_FFFC, 32'hC}, '{8'h1C, 32'hFFFF_FFFF, 32'h0}};
    pbs_sequencer DUT (.clock, .rstn, .hostAddr, .hostWdata, .hostWrite, .hostRead, .hostRdata,
        .refStableInt, .refStableExt, .devAddr, .devWdata, .devWrite, .devRead, .devRdata,
        .cacheOff);
    pbs_dev_model M (.clock, .rstn, .devAddr, .devWdata, .devWrite, .devRead, .devRdata);
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hostAddr <= a;
        hostWdata <= d;
        hostWrite <= 1'b1;
        @(posedge clock);
        hostWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        hostAddr <= a;
        hostRead <= 1'b1;
        @(posedge clock);
        hostRead <= 1'b0;
        #1 d = hostRdata;
    endtask : rd
    task automatic wait_done();
        for (int n = 0; n < 3000; n++) begin
            rd(`PBS_OFS_STATUS, v);
            if (v[`PBS_STS_DONE] === 1'b1) return;
        end
        num_errors++;
        $display("BAD %0t no done", $time);
    endtask : wait_done
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        {rstn, hostWrite, hostRead, refStableInt, refStableExt} = '0;
        {hostAddr, hostWdata, num_errors, checks_done} = '0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, v);
            `CHK(v, rows[i].r)
        end
        // Bring-up with the internal reference not yet stable
        wr(`PBS_OFS_DIV, 32'h4);
        wr(`PBS_OFS_FILT, 32'h25);
        wr(`PBS_OFS_MUL, 32'h8);
        wr(`PBS_OFS_FLASH, 32'h2);
        wr(`PBS_OFS_FALLBACK, 32'h0);
        wr(`PBS_OFS_CMD, 32'h1);
        repeat (50) @(posedge clock);
        `CHK(M.ctlWrites, 0)
        refStableInt <= 1'b1;
        refStableExt <= 1'b1;
        wait_done();
        `CHK(M.ctl[2:0], 3'h3)
        `CHK({M.div, M.filt, M.mul}, 24'h04_25_08)
        `CHK(M.flash, 8'h20)
        `CHK(M.sysclk, 8'h04)
        `CHK(M.runGap >= 1000, 1'b1)
        `CHK(v[`PBS_STS_LOCK], 1'b1)
        // Slower reconfiguration onto the external reference; a write while busy is dropped
        wr(`PBS_OFS_DIV, 32'h2);
        wr(`PBS_OFS_FLASH, 32'h1);
        wr(`PBS_OFS_CMD, 32'h6);
        wr(`PBS_OFS_DIV, 32'h77);
        wait_done();
        `CHK(M.ctl[2:0], 3'h7)
        `CHK(M.div, 8'h02)
        `CHK(M.flash, 8'h10)
        `CHK({M.sysclk, cacheOff}, 9'h008)
        // Faster reconfiguration
        wr(`PBS_OFS_FLASH, 32'h3);
        wr(`PBS_OFS_CMD, 32'hA);
        wait_done();
        `CHK({M.flash, M.sysclk}, 16'h3004)
        finish_test();
    end
    initial begin
        repeat (40000) @(posedge clock);
        num_errors++;
        $display("BAD %0t watchdog", $time);
        finish_test();
    end
endmodule : test_pbs_sequencer
bind pbs_sequencer pbs_sequencer_asserts u_chk (.clock, .rstn, .hostRead, .hostRdata,
    .devAddr, .devWdata, .devWrite, .devRead, .devRdata, .cacheOff);
